/* File: inc/core_regs_params.svh */
`ifndef CORE_REGS_PARAMS_SVH
`define CORE_REGS_PARAMS_SVH
// Data-space addresses of the core registers
`define ADDR_POINTER_ONE   8'h80
`define ADDR_POINTER_TWO   8'h81
`define ADDR_SHORT_ONE     8'h82
`define ADDR_SHORT_SECOND  8'h83
`define ADDR_ACCUMULATOR   8'hFF
// Reset values
`define RESET_BYTE         8'h00
`define RESET_PC           12'hFFE
`define RESET_BANK         4'h0
// Stack geometry
`define STACK_LEVELS       6
`define STACK_DEPTH_W      3
`define PC_WIDTH           12
`endif

/* File: inc/core_regs_pkg.sv */
package core_regs_pkg;
  // Execution contexts, one-hot
  typedef enum logic [2:0] {
    CTX_NORMAL = 3'b001,
    CTX_IRQ    = 3'b010,
    CTX_URGENT = 3'b100
  } ctx_e;
  // Program counter update sources
  typedef enum logic [2:0] {
    PC_HOLD   = 3'h0,
    PC_STEP   = 3'h1,
    PC_BRANCH = 3'h2,
    PC_LOAD   = 3'h3,
    PC_CALL   = 3'h4,
    PC_VECTOR = 3'h5,
    PC_RETURN = 3'h6
  } pc_op_e;
endpackage : core_regs_pkg

/* File: logic/cpu_core_registers_stack.sv */
`timescale 1ns/1ps
`include "core_regs_params.svh"
module cpu_core_registers_stack #(
  parameter int LEVELS = `STACK_LEVELS,
  parameter int PCW    = `PC_WIDTH
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Data-space port from the sequencer
  input  wire logic [7:0]        ds_addr,
  input  wire logic              ds_wr,
  input  wire logic [7:0]        ds_wdata,
  output logic      [7:0]        ds_rdata,
  output logic                   ds_hit,
  // Program counter control
  input  wire logic [2:0]        pc_op,
  input  wire logic [PCW-1:0]    pc_target,
  input  wire logic [7:0]        branch_offset,
  input  wire logic              bank_wr,
  input  wire logic [3:0]        bank_wdata,
  output logic      [PCW-1:0]    pc,
  output logic      [PCW+3:0]    prog_addr,
  // Context events
  input  wire logic              irq_enter,
  input  wire logic              urgent_enter,
  input  wire logic              irq_exit,
  // Flag update from the ALU
  input  wire logic              flag_c_we,
  input  wire logic              flag_c_in,
  input  wire logic              flag_z_we,
  input  wire logic              flag_z_in,
  output logic                   carry,
  output logic                   zero,
  output logic      [2:0]        context_sel,
  output logic      [LEVELS-1:0] stack_valid
);

  // Depth counter width bounds the levels; the push slice needs two
  generate
    if (LEVELS < 2 || LEVELS >= (1 << `STACK_DEPTH_W) || PCW != `PC_WIDTH)
    begin : g_bad_params
      $error("cpu_core_registers_stack: unsupported parameters");
    end
  endgenerate

  // Whole module state
  typedef struct packed {
    logic [7:0]              acc;
    logic [7:0]              ptr_one;
    logic [7:0]              ptr_two;
    logic [7:0]              sd_one;
    logic [7:0]              sd_two;
    logic [PCW-1:0]          pc;
    logic [3:0]              bank;
    logic [LEVELS-1:0][PCW-1:0] stk;
    logic [`STACK_DEPTH_W-1:0]  depth;
    core_regs_pkg::ctx_e     ctx;
    core_regs_pkg::ctx_e     prev_ctx;
    logic [2:0]              cf;
    logic [2:0]              zf;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // Shared data-space decoder for reads and writes
  function automatic logic [2:0] dec(input logic [7:0] a);
    unique case (a)
      `ADDR_ACCUMULATOR:  dec = 3'h1;
      `ADDR_POINTER_ONE:  dec = 3'h2;
      `ADDR_POINTER_TWO:  dec = 3'h3;
      `ADDR_SHORT_ONE:    dec = 3'h4;
      `ADDR_SHORT_SECOND: dec = 3'h5;
      default:            dec = 3'h0;
    endcase
  endfunction : dec

  // Context index of a one-hot code
  function automatic int unsigned cidx(input logic [2:0] c);
    cidx = c[2] ? 2 : (c[1] ? 1 : 0);
  endfunction : cidx

  logic [2:0] wsel;
  logic [2:0] rsel;
  logic [1:0] ci;
  logic [PCW-1:0] pc_inc;

  assign wsel = dec(ds_addr);
  assign rsel = dec(ds_addr);
  assign ci   = 2'(cidx(st_reg.ctx));
  assign pc_inc = st_reg.pc + 12'h001;

  // Next-state logic
  always_comb
  begin
    st_next = st_reg;
    // Every addressing mode arrives as a plain address here, so direct,
    // short direct and bit direct all resolve the same way.
    if (ds_wr)
    begin
      unique case (wsel)
        3'h1: st_next.acc     = ds_wdata;
        3'h2: st_next.ptr_one = ds_wdata;
        3'h3: st_next.ptr_two = ds_wdata;
        3'h4: st_next.sd_one  = ds_wdata;
        3'h5: st_next.sd_two  = ds_wdata;
        default: ;
      endcase
    end
    if (bank_wr)
      st_next.bank = bank_wdata;
    // Program counter sources
    unique case (pc_op)
      core_regs_pkg::PC_STEP:
        st_next.pc = pc_inc;
      core_regs_pkg::PC_BRANCH:
        st_next.pc = st_reg.pc + {{(PCW-8){branch_offset[7]}},
                                  branch_offset};
      core_regs_pkg::PC_LOAD, core_regs_pkg::PC_VECTOR:
        st_next.pc = pc_target;
      core_regs_pkg::PC_CALL:
      begin
        st_next.pc = pc_target;
        // Push; the deepest level falls off the end
        st_next.stk = {st_reg.stk[LEVELS-2:0], pc_inc};
        if (st_reg.depth != 3'(LEVELS))
          st_next.depth = st_reg.depth + 3'h1;
      end
      core_regs_pkg::PC_RETURN:
      begin
        if (st_reg.depth != 3'h0)
        begin
          st_next.pc    = st_reg.stk[0];
          st_next.stk   = {st_reg.stk[LEVELS-1], st_reg.stk[LEVELS-1:1]};
          st_next.depth = st_reg.depth - 3'h1;
        end
        else
          st_next.pc = pc_inc;
      end
      default: ;
    endcase
    // Flag writes touch only the active pair; others keep their value
    if (flag_c_we)
      st_next.cf[ci] = flag_c_in;
    if (flag_z_we)
      st_next.zf[ci] = flag_z_in;
    // Context switching; only one level of return memory is kept
    if (urgent_enter)
    begin
      st_next.prev_ctx = st_reg.ctx;
      st_next.ctx      = core_regs_pkg::CTX_URGENT;
    end
    else if (irq_enter)
    begin
      st_next.prev_ctx = st_reg.ctx;
      st_next.ctx      = core_regs_pkg::CTX_IRQ;
    end
    else if (irq_exit)
    begin
      st_next.ctx      = st_reg.prev_ctx;
      st_next.prev_ctx = core_regs_pkg::CTX_NORMAL;
    end
  end

  // State register; reset enters the non-maskable context
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg          <= '0;
      st_reg.pc       <= `RESET_PC;
      st_reg.bank     <= `RESET_BANK;
      st_reg.ctx      <= core_regs_pkg::CTX_URGENT;
      st_reg.prev_ctx <= core_regs_pkg::CTX_NORMAL;
    end
    else
      st_reg <= st_next;
  end

  // Read mux and outputs
  always_comb
  begin
    unique case (rsel)
      3'h1:    ds_rdata = st_reg.acc;
      3'h2:    ds_rdata = st_reg.ptr_one;
      3'h3:    ds_rdata = st_reg.ptr_two;
      3'h4:    ds_rdata = st_reg.sd_one;
      3'h5:    ds_rdata = st_reg.sd_two;
      default: ds_rdata = `RESET_BYTE;
    endcase
    ds_hit = (rsel != 3'h0);
  end

  assign pc          = st_reg.pc;
  assign prog_addr   = {st_reg.bank, st_reg.pc};
  assign carry       = st_reg.cf[ci];
  assign zero        = st_reg.zf[ci];
  assign context_sel = st_reg.ctx;

  // Occupancy view of the stack, one bit per filled level
  genvar g;
  generate
    for (g = 0; g < LEVELS; g++)
    begin : g_valid
      assign stack_valid[g] = (st_reg.depth > 3'(g));
    end
  endgenerate

  // Data-space checks; reads are combinational, writes land next edge
  acc_write_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ds_wr && ds_addr == `ADDR_ACCUMULATOR
    |=> st_reg.acc == $past(ds_wdata))
    else $error("accumulator write lost");
  ptr_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ds_addr == `ADDR_POINTER_TWO |-> ds_rdata == st_reg.ptr_two)
    else $error("pointer read mismatch");
  ptr_write_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ds_wr && ds_addr == `ADDR_POINTER_ONE
    |=> st_reg.ptr_one == $past(ds_wdata))
    else $error("pointer write lost");
  short_write_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ds_wr && ds_addr == `ADDR_SHORT_SECOND
    |=> st_reg.sd_two == $past(ds_wdata))
    else $error("short-direct write lost");
  decode_hit_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ds_hit == (ds_addr inside {`ADDR_POINTER_ONE, `ADDR_POINTER_TWO,
      `ADDR_SHORT_ONE, `ADDR_SHORT_SECOND, `ADDR_ACCUMULATOR}))
    else $error("data-space decode wrong");
  // Program counter checks
  pc_step_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    pc_op == core_regs_pkg::PC_STEP |=> pc == $past(pc) + 12'h001)
    else $error("pc step wrong");
  branch_add_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    pc_op == core_regs_pkg::PC_BRANCH
    |=> pc == $past(pc) + {{(PCW-8){$past(branch_offset[7])}},
                           $past(branch_offset)})
    else $error("branch sum wrong");
  jump_load_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    pc_op == core_regs_pkg::PC_LOAD || pc_op == core_regs_pkg::PC_VECTOR
    |=> pc == $past(pc_target))
    else $error("pc load wrong");
  bank_load_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    bank_wr |=> prog_addr[PCW+3:PCW] == $past(bank_wdata))
    else $error("bank write lost");
  // Return stack checks
  call_push_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    pc_op == core_regs_pkg::PC_CALL
    |=> st_reg.stk[0] == $past(pc) + 12'h001 && pc == $past(pc_target))
    else $error("call push wrong");
  ret_pop_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    pc_op == core_regs_pkg::PC_RETURN && st_reg.depth != 3'h0
    |=> pc == $past(st_reg.stk[0]))
    else $error("return pop wrong");
  stack_cap_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    st_reg.depth <= 3'(LEVELS))
    else $error("stack depth overflow");
  deep_drop_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    pc_op == core_regs_pkg::PC_CALL && st_reg.depth == 3'(LEVELS)
    |=> st_reg.depth == 3'(LEVELS)
        && st_reg.stk[LEVELS-1] == $past(st_reg.stk[LEVELS-2]))
    else $error("overflow push wrong");
  empty_ret_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    pc_op == core_regs_pkg::PC_RETURN && st_reg.depth == 3'h0
    |=> pc == $past(pc) + 12'h001 && st_reg.depth == 3'h0)
    else $error("empty return wrong");
  stack_shape_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (LEVELS'(stack_valid + 1'b1) & stack_valid) == '0)
    else $error("stack occupancy not contiguous");
  // Context and flag checks; a flag write in a switch cycle hits the old pair
  reset_ctx_a: assert property (
    @(posedge mclk)
    $rose(rst_n) |-> context_sel == core_regs_pkg::CTX_URGENT
      && pc == `RESET_PC && stack_valid == '0)
    else $error("reset state wrong");
  ctx_onehot_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $onehot(context_sel))
    else $error("context code illegal");
  urgent_entry_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    urgent_enter |=> context_sel == core_regs_pkg::CTX_URGENT)
    else $error("urgent entry missed");
  irq_entry_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    irq_enter && !urgent_enter |=> context_sel == core_regs_pkg::CTX_IRQ)
    else $error("interrupt entry missed");
  irq_ctx_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    irq_enter && !urgent_enter ##1 irq_exit && !irq_enter && !urgent_enter
    |=> context_sel == $past(context_sel, 2))
    else $error("context not restored");
  flag_keep_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (irq_enter || urgent_enter || irq_exit) && !flag_c_we
    |=> st_reg.cf == $past(st_reg.cf))
    else $error("flags changed on switch");
  pair_guard_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    flag_c_we |=> (st_reg.cf & ~$past(st_reg.ctx))
      == ($past(st_reg.cf) & ~$past(st_reg.ctx)))
    else $error("inactive carry touched");
  carry_write_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    flag_c_we && !irq_enter && !urgent_enter && !irq_exit
    |=> carry == $past(flag_c_in))
    else $error("carry write lost");
  zero_write_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    flag_z_we && !irq_enter && !urgent_enter && !irq_exit
    |=> zero == $past(flag_z_in))
    else $error("zero write lost");

endmodule : cpu_core_registers_stack

/* File: verif/seq_model.sv */
`timescale 1ns/1ps
module seq_model (
  // Clock
  input  wire logic mclk,
  // Requests toward the register block
  output logic [7:0]  ds_addr,
  output logic        ds_wr,
  output logic [7:0]  ds_wdata,
  output logic [2:0]  pc_op,
  output logic [11:0] pc_target,
  output logic [7:0]  branch_offset,
  output logic        bank_wr,
  output logic [3:0]  bank_wdata,
  output logic [2:0]  ev,
  output logic [3:0]  fl
);
  // Idle until the first request
  initial
  begin
    {ds_addr, ds_wr, ds_wdata, pc_op, pc_target} = '0;
    {branch_offset, bank_wr, bank_wdata, ev, fl} = '0;
  end
  // A request stays driven after its sampling edge until the next issue; calls run back to back, so none is taken twice
  task automatic issue(input logic [2:0] op, input logic [11:0] tgt,
    input logic [7:0] off, input logic [2:0] e, input logic [3:0] f,
    input logic [8:0] w, input logic [7:0] wd, input logic [4:0] bk);
    {pc_op, pc_target, branch_offset, ev, fl} = {op, tgt, off, e, f};
    {ds_wr, ds_addr, ds_wdata, bank_wr, bank_wdata} = {w, wd, bk};
    @(posedge mclk);
    #1;
  endtask : issue
endmodule : seq_model

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        mclk;
  logic        rst_n;
  logic [7:0]  ds_addr, ds_wdata, ds_rdata, branch_offset;
  logic        ds_wr, ds_hit, bank_wr, carry, zero;
  logic [2:0]  pc_op, ev, context_sel;
  logic [11:0] pc_target, pc, t;
  logic [3:0]  bank_wdata, fl, bank_m;
  logic [15:0] prog_addr;
  logic [5:0]  stack_valid;
  // Reference state of the register block
  logic [11:0] pc_m;
  logic [11:0] stk[$];
  logic [2:0]  ctx_m, prev_m;
  logic        c_m[3], z_m[3];
  logic [7:0]  rf[256];
  int          error_cnt = 0;
  int          comparisons = 0;
  // 10 MHz core clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  seq_model seq (.mclk, .ds_addr, .ds_wr, .ds_wdata, .pc_op, .pc_target,
    .branch_offset, .bank_wr, .bank_wdata, .ev, .fl);
  cpu_core_registers_stack dut (.mclk, .rst_n, .ds_addr, .ds_wr, .ds_wdata,
    .ds_rdata, .ds_hit, .pc_op, .pc_target, .branch_offset, .bank_wr,
    .bank_wdata, .pc, .prog_addr, .irq_enter(ev[1]), .urgent_enter(ev[2]),
    .irq_exit(ev[0]), .flag_c_we(fl[3]), .flag_c_in(fl[2]),
    .flag_z_we(fl[1]), .flag_z_in(fl[0]), .carry, .zero, .context_sel,
    .stack_valid);
  function automatic bit hit(input logic [7:0] a);
    return a inside {8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
  endfunction : hit
  task automatic conclude();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic mreset();
    pc_m = 12'hFFE;
    stk = {};
    bank_m = 4'h0;
    ctx_m = 3'h4;
    prev_m = 3'h1;
    c_m = '{default: 1'b0};
    z_m = '{default: 1'b0};
    foreach (rf[j]) rf[j] = 8'h00;
  endtask : mreset
  // Every visible output against the reference after each edge
  task automatic chk_all();
    chk("pc", pc_m, pc);
    chk("prog_addr", {bank_m, pc_m}, prog_addr);
    chk("stack_valid", (16'h1 << stk.size()) - 16'h1, stack_valid);
    chk("context_sel", ctx_m, context_sel);
    chk("carry", c_m[ctx_m >> 1], carry);
    chk("zero", z_m[ctx_m >> 1], zero);
    chk("ds_hit", hit(ds_addr), ds_hit);
    chk("ds_rdata", hit(ds_addr) ? rf[ds_addr] : 8'h00, ds_rdata);
  endtask : chk_all
  // One request, then the reference steps with the old state as cause
  task automatic go(input logic [2:0] op, input logic [11:0] tgt,
    input logic [7:0] off, input logic [2:0] e, input logic [3:0] f,
    input logic [8:0] w, input logic [7:0] wd, input logic [4:0] bk);
    int i;
    i = ctx_m >> 1;
    seq.issue(op, tgt, off, e, f, w, wd, bk);
    case (op)
      3'h1: pc_m = pc_m + 12'h001;
      3'h2: pc_m = pc_m + {{4{off[7]}}, off};
      3'h3, 3'h5: pc_m = tgt;
      3'h4:
      begin
        stk.push_front(pc_m + 12'h001);
        if (stk.size() > 6)
          void'(stk.pop_back());
        pc_m = tgt;
      end
      3'h6: pc_m = stk.size() ? stk.pop_front() : pc_m + 12'h001;
      default: ;
    endcase
    if (e[2] || e[1])
    begin
      prev_m = ctx_m;
      ctx_m = e[2] ? 3'h4 : 3'h2;
    end
    else if (e[0])
    begin
      ctx_m = prev_m;
      prev_m = 3'h1;
    end
    c_m[i] = f[3] ? f[2] : c_m[i];
    z_m[i] = f[1] ? f[0] : z_m[i];
    bank_m = bk[4] ? bk[3:0] : bank_m;
    if (w[8] && hit(w[7:0]))
      rf[w[7:0]] = wd;
    chk_all();
  endtask : go
  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (2000) @(posedge mclk);
    error_cnt++;
    conclude();
  end
  initial
  begin
    logic [2:0] evs [5];
    logic [7:0] adr [8];
    logic [2:0] op;
    evs = '{3'h1, 3'h2, 3'h4, 3'h1, 3'h1};
    adr = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'h84, 8'h00, 8'h7F};
    void'($urandom(22));
    rst_n = 1'b0;
    mreset();
    repeat (20) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    chk_all();
    // Write all places, unmapped ones too, then read each back
    for (int j = 0; j < 16; j++)
      go(3'h1, 12'h000, 8'h00, 3'h0, 4'h0, {j < 8, adr[j % 8]},
        8'($urandom), 5'h00);
    // Context walk with a random flag request, write enables included or not, in each context
    foreach (evs[j])
    begin
      go(3'h0, 12'h000, 8'h00, evs[j], 4'h0, 9'h000, 8'h00, 5'h00);
      go(3'h0, 12'h000, 8'h00, 3'h0, 4'($urandom), 9'h000, 8'h00,
        5'h00);
    end
    // Overflow by two, then underflow by two
    for (int j = 0; j < 16; j++)
      go(j < 8 ? 3'h4 : 3'h6, 12'($urandom), 8'h00, 3'h0, 4'h0, 9'h000,
        8'h00, 5'h00);
    for (int j = 0; j < 200; j++)
    begin
      op = 3'($urandom % 7);
      go(op, 12'($urandom), 8'($urandom), 3'($urandom),
        4'($urandom), {1'($urandom), adr[$urandom % 8]}, 8'($urandom),
        5'($urandom));
    end
    // Vector load, then a reset in mid-run
    t = 12'($urandom);
    seq.issue(3'h5, t, 8'h00, 3'h0, 4'h0, 9'h000, 8'h00, 5'h00);
    chk("vector", t, pc);
    rst_n = 1'b0;
    mreset();
    go(3'h0, 12'h000, 8'h00, 3'h0, 4'h0, 9'h000, 8'h00, 5'h00);
    rst_n = 1'b1;
    go(3'h1, 12'h000, 8'h00, 3'h0, 4'h0, 9'h0FF, 8'h00, 5'h00);
    conclude();
  end
endmodule : testbench
